// >>> rtl/hwr_pkg.sv
// Constants shared by both ends of the hardware reset and start-up link.
// Assumes a single 40 MHz system clock feeding both ends.
package hwr_pkg;
    localparam int          CLK_MHZ        = 40;
    // Reset pulse low time and high interval, minimum, in microseconds.
    localparam int          RST_LOW_US     = 1;
    localparam int          RST_HIGH_US    = 1;
    localparam int          RST_LOW_CYC    = RST_LOW_US * CLK_MHZ;
    localparam int          RST_HIGH_CYC   = RST_HIGH_US * CLK_MHZ;
    // Reset release to first command, minimum, in microseconds.
    localparam int          RSCA_US        = 200;
    localparam int          RSCA_CYC       = RSCA_US * CLK_MHZ;
    localparam int          TIME_W         = 14;
    // Link clock cycles needed before the identification commands.
    localparam logic [6:0]  INIT_CLKS      = 7'h4A;
    localparam logic [31:0] CMD_BOOT_ARG   = 32'h0FFFFFFA;
    localparam logic [5:0]  CMD_GO_IDLE    = 6'h00;
    localparam logic [5:0]  CMD_SEND_OP    = 6'h01;
    localparam logic [5:0]  CMD_WP_STATUS  = 6'h1E;
    localparam logic [5:0]  CMD_WP_TYPE    = 6'h1F;
    // Half period of the link clock in system cycles (10 MHz link clock).
    localparam logic [1:0]  LINK_HALF      = 2'h2;
    // Least spacing between two commands, long enough for the far
    // end's two-stage synchroniser and capture stage.
    localparam logic [3:0]  CMD_GAP        = 4'h8;
    localparam logic [2:0]  REPEAT_LIMIT   = 3'h4;
    localparam int          PWR_INIT_CYC   = 64;
    localparam logic [5:0]  INT_RST_CYC    = 6'h20;
    localparam logic [31:0] PRELOAD_BASE   = 32'h0100_0000;
    localparam logic [31:0] RESET_ZERO32   = 32'h0000_0000;
endpackage

// >>> rtl/hwr_link_if.sv
// Link between the host controller and the managed flash device.
// Carries the reset line, the link clock and a simple command strobe.
interface hwr_link_if;
    logic        rst_n;
    logic        lclk;
    logic        cmd_tog;
    logic [5:0]  cmd_idx;
    logic [31:0] cmd_arg;
    modport host   (output rst_n, output lclk, output cmd_tog,
                    output cmd_idx, output cmd_arg);
    modport device (input rst_n, input lclk, input cmd_tog,
                    input cmd_idx, input cmd_arg);
endinterface

// >>> rtl/hwr_device.sv
// Device end: reset detection, power-on initialisation, pre-load limit.
// Assumes every link signal is asynchronous to I_CLK_SYS.
module hwr_device
    import hwr_pkg::*;
(
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_RESETN,
    hwr_link_if.device       LINK,
    input  wire logic        I_RST_FN_EN,
    input  wire logic        I_ENH_CFG_VALID,
    input  wire logic [31:0] I_ENH_SIZE,
    input  wire logic        I_PRELOAD_WR,
    input  wire logic [15:0] I_PRELOAD_BYTES,
    output logic             O_INIT_DONE,
    output logic             O_INT_RESET,
    output logic             O_CMD_VALID,
    output logic [5:0]       O_CMD_IDX,
    output logic [31:0]      O_CMD_ARG,
    output logic             O_EARLY_CMD,
    output logic [31:0]      O_MAX_PRELOAD,
    output logic             O_PRELOAD_ACK,
    output logic             O_PRELOAD_REFUSED,
    output logic [31:0]      O_PRELOAD_USED
);
    logic [2:0]  rst_s_q, clk_s_q, tog_s_q;
    logic [37:0] dat_s1_q, dat_s2_q;
    logic [6:0]  init_cnt_q;
    logic        rst_en_q;
    logic [5:0]  irst_cnt_q;
    logic [6:0]  lclk_cnt_q;
    logic        cmd_v_q, early_q, ack_q, ref_q;
    logic [5:0]  idx_q;
    logic [31:0] arg_q, max_q, used_q;

    wire init_done = (init_cnt_q == 7'(PWR_INIT_CYC));
    wire rst_rise  = rst_s_q[1] & ~rst_s_q[2];
    // Until initialisation ends the reset enable is unknown, so the line
    // is ignored; afterwards only an enabled device reacts.
    wire rst_act   = rst_rise & init_done & rst_en_q;
    wire in_rst    = (irst_cnt_q != 6'h00) | ~rst_s_q[1];
    wire clk_rise  = clk_s_q[1] & ~clk_s_q[2];
    wire cmd_new   = (tog_s_q[1] ^ tog_s_q[2]) & init_done & ~in_rst;
    wire [5:0]  n_idx = dat_s2_q[37:32];
    wire [31:0] n_arg = dat_s2_q[31:0];
    wire id_cmd    = (n_idx == CMD_SEND_OP) |
                     ((n_idx == CMD_GO_IDLE) & (n_arg == CMD_BOOT_ARG));
    wire [32:0] used_sum = {1'b0, used_q} + {17'h00000, I_PRELOAD_BYTES};
    wire pre_fits  = (used_sum <= {1'b0, max_q});
    wire [31:0] enh_max = (I_ENH_SIZE >= PRELOAD_BASE) ? RESET_ZERO32 :
                          PRELOAD_BASE - I_ENH_SIZE;

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rst_s_q  <= 3'h7;
            clk_s_q  <= 3'h0;
            tog_s_q  <= 3'h0;
            dat_s1_q <= 38'h00_0000_0000;
            dat_s2_q <= 38'h00_0000_0000;
        end else begin
            rst_s_q  <= {rst_s_q[1:0], LINK.rst_n};
            clk_s_q  <= {clk_s_q[1:0], LINK.lclk};
            tog_s_q  <= {tog_s_q[1:0], LINK.cmd_tog};
            dat_s1_q <= {LINK.cmd_idx, LINK.cmd_arg};
            dat_s2_q <= dat_s1_q;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            init_cnt_q <= 7'h00;
            rst_en_q   <= 1'b0;
        end else if (!init_done) begin
            init_cnt_q <= init_cnt_q + 7'h01;
            // The enable is loaded as the last step of initialisation.
            if (init_cnt_q == 7'(PWR_INIT_CYC - 1)) begin
                rst_en_q <= I_RST_FN_EN;
            end
        end
    end

    // A rising reset edge starts the internal reset sequence.
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            irst_cnt_q <= 6'h00;
        end else if (rst_act) begin
            irst_cnt_q <= INT_RST_CYC;
        end else if (irst_cnt_q != 6'h00) begin
            irst_cnt_q <= irst_cnt_q - 6'h01;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            lclk_cnt_q <= 7'h00;
            early_q    <= 1'b0;
            cmd_v_q    <= 1'b0;
            idx_q      <= 6'h00;
            arg_q      <= RESET_ZERO32;
        end else begin
            cmd_v_q <= cmd_new;
            // Only a low line restarts the count. The host counts its
            // start-up clocks from the release, not from our own reset.
            if (!rst_s_q[1]) begin
                lclk_cnt_q <= 7'h00;
            end else if (clk_rise && lclk_cnt_q != INIT_CLKS) begin
                lclk_cnt_q <= lclk_cnt_q + 7'h01;
            end
            if (cmd_new) begin
                idx_q <= n_idx;
                arg_q <= n_arg;
                if (id_cmd && lclk_cnt_q != INIT_CLKS) begin
                    early_q <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            max_q  <= PRELOAD_BASE;
            used_q <= RESET_ZERO32;
            ack_q  <= 1'b0;
            ref_q  <= 1'b0;
        end else begin
            ack_q <= I_PRELOAD_WR & pre_fits;
            ref_q <= I_PRELOAD_WR & ~pre_fits;
            if (I_ENH_CFG_VALID) begin
                max_q <= enh_max;
            end
            if (I_PRELOAD_WR && pre_fits) begin
                used_q <= used_sum[31:0];
            end
        end
    end

    assign O_INIT_DONE       = init_done;
    assign O_INT_RESET       = (irst_cnt_q != 6'h00);
    assign O_CMD_VALID       = cmd_v_q;
    assign O_CMD_IDX         = idx_q;
    assign O_CMD_ARG         = arg_q;
    assign O_EARLY_CMD       = early_q;
    assign O_MAX_PRELOAD     = max_q;
    assign O_PRELOAD_ACK     = ack_q;
    assign O_PRELOAD_REFUSED = ref_q;
    assign O_PRELOAD_USED    = used_q;
endmodule

// >>> rtl/hwr_host.sv
// Host end: drives the reset line, the link clock and the command strobe.
// Assumes user requests come from logic on I_CLK_SYS.
module hwr_host
    import hwr_pkg::*;
#(
    parameter int RSCA_CYCLES = RSCA_CYC
)
(
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_RESETN,
    hwr_link_if.host         LINK,
    input  wire logic        I_RESET_REQ,
    input  wire logic        I_CMD_REQ,
    input  wire logic [5:0]  I_CMD_IDX,
    input  wire logic [31:0] I_CMD_ARG,
    output logic             O_RESET_READY,
    output logic             O_CMD_READY,
    output logic             O_RESET_BUSY,
    output logic             O_CMD_SENT,
    output logic             O_REPEAT_WARN
);
    typedef enum logic [0:0] {HS_HIGH, HS_LOW} hwr_hstate_t;

    hwr_hstate_t        state_q, state_d;
    logic [TIME_W-1:0]  low_cnt_q;
    logic [TIME_W-1:0]  hi_cnt_q;
    logic [1:0]         div_cnt_q;
    logic               lclk_q;
    logic [6:0]         lclk_cnt_q;
    logic [3:0]         gap_q;
    logic               tog_q;
    logic [5:0]         idx_q;
    logic [31:0]        arg_q;
    logic               sent_q;
    logic [2:0]         rep_cnt_q;
    logic               warn_q;

    localparam logic [TIME_W-1:0] LOW_MIN  = TIME_W'(RST_LOW_CYC);
    localparam logic [TIME_W-1:0] HIGH_MIN = TIME_W'(RST_HIGH_CYC);
    localparam logic [TIME_W-1:0] CMD_MIN  = TIME_W'(RSCA_CYCLES);
    localparam logic [TIME_W-1:0] HI_SAT   =
        (CMD_MIN > HIGH_MIN) ? CMD_MIN : HIGH_MIN;

    // Link clock divider; the clock runs free so the device always sees
    // edges, including while the reset line is low.
    wire div_wrap  = (div_cnt_q == LINK_HALF - 2'h1);
    wire lclk_rise = div_wrap & ~lclk_q;

    wire in_high   = (state_q == HS_HIGH);
    wire hi_done   = (hi_cnt_q >= HIGH_MIN);
    wire low_done  = (low_cnt_q >= LOW_MIN - TIME_W'(1));
    wire wait_done = (hi_cnt_q >= CMD_MIN);
    wire clks_done = (lclk_cnt_q == INIT_CLKS);
    wire id_cmd    = (I_CMD_IDX == CMD_SEND_OP) |
                     ((I_CMD_IDX == CMD_GO_IDLE) &&
                      (I_CMD_ARG == CMD_BOOT_ARG));
    wire wp_cmd    = (I_CMD_IDX == CMD_WP_STATUS) |
                     (I_CMD_IDX == CMD_WP_TYPE);
    // Identification commands also need the start-up clocks.
    wire cmd_ok    = in_high & wait_done & (gap_q == 4'h0) &
                     (~id_cmd | clks_done);
    wire rst_ok    = in_high & hi_done;
    wire cmd_take  = I_CMD_REQ & cmd_ok;
    wire rst_take  = I_RESET_REQ & rst_ok & ~cmd_take;
    // Resets, CMD1 and the write-protect queries all cause internal reads.
    wire rep_evt   = rst_take |
                     (cmd_take & ((I_CMD_IDX == CMD_SEND_OP) | wp_cmd));
    wire rep_full  = (rep_cnt_q == REPEAT_LIMIT);

    always_comb begin
        state_d = state_q;
        case (state_q)
            HS_HIGH: begin
                if (rst_take) begin
                    state_d = HS_LOW;
                end
            end
            HS_LOW: begin
                if (low_done) begin
                    state_d = HS_HIGH;
                end
            end
            default: begin
                state_d = HS_HIGH;
            end
        endcase
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_q <= HS_HIGH;
        end else begin
            state_q <= state_d;
        end
    end

    // Low time and time since release are counted separately; the
    // release counter saturates so it never wraps back below a limit.
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            low_cnt_q <= '0;
        end else if (state_q == HS_LOW) begin
            low_cnt_q <= low_cnt_q + TIME_W'(1);
        end else begin
            low_cnt_q <= '0;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            hi_cnt_q <= '0;
        end else if (state_q == HS_LOW) begin
            hi_cnt_q <= '0;
        end else if (hi_cnt_q != HI_SAT) begin
            hi_cnt_q <= hi_cnt_q + TIME_W'(1);
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            div_cnt_q <= 2'h0;
            lclk_q    <= 1'b0;
        end else begin
            div_cnt_q <= div_wrap ? 2'h0 : div_cnt_q + 2'h1;
            if (div_wrap) begin
                lclk_q <= ~lclk_q;
            end
        end
    end

    // Rises count only while the line is high, so every reset pulse
    // restarts the start-up clock count.
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            lclk_cnt_q <= 7'h00;
        end else if (!in_high) begin
            lclk_cnt_q <= 7'h00;
        end else if (lclk_rise && !clks_done) begin
            lclk_cnt_q <= lclk_cnt_q + 7'h01;
        end
    end

    // Index and argument settle with the toggle and then stand still for
    // the whole gap, so the far end can sample them after its sync.
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            tog_q  <= 1'b0;
            idx_q  <= 6'h00;
            arg_q  <= RESET_ZERO32;
            sent_q <= 1'b0;
        end else begin
            sent_q <= cmd_take;
            if (cmd_take) begin
                tog_q <= ~tog_q;
                idx_q <= I_CMD_IDX;
                arg_q <= I_CMD_ARG;
            end
        end
    end

    // The gap keeps the fields still until the far end has captured them.
    // A shorter gap would let a second toggle overtake the first capture.
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            gap_q <= 4'h0;
        end else if (cmd_take) begin
            gap_q <= CMD_GAP;
        end else if (gap_q != 4'h0) begin
            gap_q <= gap_q - 4'h1;
        end
    end

    // Repetition is only warned about; refusing would block recovery.
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rep_cnt_q <= 3'h0;
            warn_q    <= 1'b0;
        end else if (rep_evt) begin
            if (rep_full) begin
                warn_q <= 1'b1;
            end else begin
                rep_cnt_q <= rep_cnt_q + 3'h1;
            end
        end
    end

    // The line is high except during a requested pulse.
    assign LINK.rst_n  = in_high;
    assign LINK.lclk   = lclk_q;
    assign LINK.cmd_tog = tog_q;
    assign LINK.cmd_idx = idx_q;
    assign LINK.cmd_arg = arg_q;

    assign O_RESET_READY = rst_ok;
    assign O_CMD_READY   = cmd_ok;
    assign O_RESET_BUSY  = ~in_high;
    assign O_CMD_SENT    = sent_q;
    assign O_REPEAT_WARN = warn_q;
endmodule

// >>> testbench/hwr_checker.sv
// Concurrent checks on the link signals between host and device ends.
// Assumes the testbench top hands it the link and the system clock.
module hwr_checker
    import hwr_pkg::*;
#(
    parameter int RSCA_CYCLES = RSCA_CYC
)
(
    input wire logic        I_CLK_SYS,
    input wire logic        I_RESETN,
    input wire logic        rst_n,
    input wire logic        lclk,
    input wire logic        cmd_tog,
    input wire logic [5:0]  cmd_idx,
    input wire logic [31:0] cmd_arg
);
    logic [31:0] low_q;
    logic [31:0] high_q;
    logic [31:0] rise_q;
    logic        lclk_q;
    logic        tog_q;
    wire         new_cmd = cmd_tog ^ tog_q;
    wire         id_cmd  = cmd_idx == CMD_SEND_OP ||
                           (cmd_idx == CMD_GO_IDLE && cmd_arg == CMD_BOOT_ARG);

    // Wide counters so that no run length can wrap them into a false pass.
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            {low_q, high_q, rise_q, lclk_q, tog_q} <= '0;
        end else begin
            low_q  <= rst_n ? 32'h0 : low_q + 32'h1;
            high_q <= rst_n ? high_q + 32'h1 : 32'h0;
            rise_q <= !rst_n ? 32'h0 : rise_q + 32'(lclk && !lclk_q);
            lclk_q <= lclk;
            tog_q  <= cmd_tog;
        end
    end

    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESETN);

    sequence low_run;
        !rst_n [*8];
    endsequence
    sequence clk_period;
        lclk [*2] ##1 !lclk [*2] ##1 lclk;
    endsequence

    pulse_shape_a: assert property (
        $fell(rst_n) |-> low_run ##[32:33] rst_n)
        else $error("reset low pulse length wrong");
    low_len_a: assert property (
        $rose(rst_n) |-> low_q >= RST_LOW_CYC)
        else $error("reset low pulse too short");
    high_len_a: assert property (
        $fell(rst_n) |-> high_q >= RST_HIGH_CYC)
        else $error("reset high interval too short");
    cmd_wait_a: assert property (
        new_cmd |-> high_q >= RSCA_CYCLES)
        else $error("command too soon after reset");
    id_clocks_a: assert property (
        new_cmd && id_cmd |-> rise_q >= INIT_CLKS)
        else $error("identify command before enough clocks");
    lclk_rate_a: assert property (
        $rose(lclk) |-> clk_period)
        else $error("link clock shape wrong");
    cmd_hold_a: assert property (new_cmd |=>
        ($stable(cmd_idx) && $stable(cmd_arg) && !new_cmd) [*7])
        else $error("command fields not held");
    idle_high_a: assert property (
        $rose(I_RESETN) |-> rst_n && !new_cmd)
        else $error("reset line not idle after release");
endmodule

// >>> testbench/hwr_tb.sv
// Self-checking bench joining host and device ends over one link.
// Assumes the package, link interface, both ends and checker are compiled.
module hwr_tb
    import hwr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Short release-to-command wait keeps the run brief.
    localparam int RSCA = 100;
    logic        clk = 1'b0;
    logic        sys_rst_n, rst_req, cmd_req, fn_en, enh_vld, pre_wr;
    logic [5:0]  cmd_idx;
    logic [31:0] cmd_arg, enh_size;
    logic [15:0] pre_bytes;
    wire logic   rst_rdy, cmd_rdy, rst_busy, cmd_sent, rep_warn;
    wire logic   init_done, int_rst, c_vld, early, pre_ack, pre_ref;
    wire logic [5:0]  c_idx;
    wire logic [31:0] c_arg, max_pre, pre_used;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          t_rise;

    hwr_link_if link();
    hwr_host #(.RSCA_CYCLES(RSCA)) hwr_host_i (.I_CLK_SYS(clk),
        .I_RESETN(sys_rst_n), .LINK(link), .I_RESET_REQ(rst_req),
        .I_CMD_REQ(cmd_req), .I_CMD_IDX(cmd_idx), .I_CMD_ARG(cmd_arg),
        .O_RESET_READY(rst_rdy), .O_CMD_READY(cmd_rdy),
        .O_RESET_BUSY(rst_busy), .O_CMD_SENT(cmd_sent),
        .O_REPEAT_WARN(rep_warn));
    hwr_device hwr_device_i (.I_CLK_SYS(clk), .I_RESETN(sys_rst_n),
        .LINK(link), .I_RST_FN_EN(fn_en), .I_ENH_CFG_VALID(enh_vld),
        .I_ENH_SIZE(enh_size), .I_PRELOAD_WR(pre_wr),
        .I_PRELOAD_BYTES(pre_bytes), .O_INIT_DONE(init_done),
        .O_INT_RESET(int_rst), .O_CMD_VALID(c_vld), .O_CMD_IDX(c_idx),
        .O_CMD_ARG(c_arg), .O_EARLY_CMD(early), .O_MAX_PRELOAD(max_pre),
        .O_PRELOAD_ACK(pre_ack), .O_PRELOAD_REFUSED(pre_ref),
        .O_PRELOAD_USED(pre_used));
    hwr_checker #(.RSCA_CYCLES(RSCA)) hwr_checker_i (.I_CLK_SYS(clk),
        .I_RESETN(sys_rst_n), .rst_n(link.rst_n), .lclk(link.lclk),
        .cmd_tog(link.cmd_tog), .cmd_idx(link.cmd_idx),
        .cmd_arg(link.cmd_arg));

    always #12.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    task automatic chk(input bit ok, input string msg);
        n_compared++;
        if (!ok) begin
            n_mismatch++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask

    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic t_power();
        chk(link.rst_n === 1'b1, "line not idle high");
        chk(max_pre === PRELOAD_BASE, "preload maximum at reset");
        for (int k = 0; k < 200 && init_done !== 1'b1; k++) @(negedge clk);
        chk(init_done === 1'b1, "init never done");
        $display("test power done");
    endtask

    task automatic t_reset();
        int k;
        for (k = 0; k < 200 && rst_rdy !== 1'b1; k++) @(negedge clk);
        @(posedge clk) rst_req <= 1'b1;
        @(posedge clk) rst_req <= 1'b0;
        @(negedge clk);
        for (k = 0; k < 100 && link.rst_n === 1'b0; k++) @(negedge clk);
        chk(k == RST_LOW_CYC, "reset low length");
        t_rise = cyc;
        for (k = 0; k < 10 && int_rst !== 1'b1; k++) @(negedge clk);
        chk(k >= 2 && k <= 4, "internal reset start");
        for (k = 0; k < 100 && int_rst === 1'b1; k++) @(negedge clk);
        chk(k == INT_RST_CYC, "internal reset length");
        // Too soon after release: the host must not start another pulse.
        @(posedge clk) rst_req <= 1'b1;
        @(negedge clk);
        chk(rst_rdy === 1'b0, "reset ready too soon");
        @(posedge clk) rst_req <= 1'b0;
        repeat (3) @(negedge clk);
        chk(link.rst_n === 1'b1 && rst_busy === 1'b0, "early reset");
        $display("test reset done");
    endtask

    task automatic t_cmds();
        logic [5:0] idx [5] = '{CMD_WP_STATUS, CMD_SEND_OP, CMD_WP_TYPE,
                                CMD_GO_IDLE, CMD_WP_TYPE};
        int k;
        int t;
        for (int n = 0; n < 5; n++) begin
            @(posedge clk);
            cmd_idx <= idx[n];
            cmd_arg <= idx[n] == CMD_GO_IDLE ? CMD_BOOT_ARG : 32'hC0DE_0000;
            cmd_req <= 1'b1;
            for (k = 0; k < 600 && cmd_sent !== 1'b1; k++) @(negedge clk);
            chk(cmd_rdy === 1'b0, "ready inside gap");
            @(posedge clk) cmd_req <= 1'b0;
            t = cyc - t_rise;
            if (n == 0) chk(t >= RSCA && t < RSCA + 20, "cmd wait");
            if (n == 1) chk(t >= 4 * (INIT_CLKS - 1), "few clocks");
            @(negedge clk);
            for (k = 0; k < 8 && c_vld !== 1'b1; k++) @(negedge clk);
            chk(c_vld === 1'b1 && c_idx === idx[n] && c_arg === cmd_arg,
                "command lost");
            chk(rep_warn === (n == 4), "repeat warning");
            chk(early === 1'b0, "identify flagged early");
        end
        $display("test commands done");
    endtask

    task automatic pre(input logic [15:0] n, input logic ack,
                       input logic [31:0] used);
        @(posedge clk);
        pre_bytes <= n;
        pre_wr <= 1'b1;
        @(posedge clk) pre_wr <= 1'b0;
        @(negedge clk);
        chk(pre_ack === ack && pre_ref === !ack && pre_used === used,
            "preload cap");
    endtask

    task automatic t_pre();
        @(posedge clk);
        enh_size <= PRELOAD_BASE - 32'h0000_0100;
        enh_vld <= 1'b1;
        @(posedge clk) enh_vld <= 1'b0;
        @(negedge clk);
        chk(max_pre === 32'h0000_0100, "reported maximum");
        pre(16'h00FF, 1'b1, 32'h0000_00FF);
        pre(16'h0001, 1'b1, 32'h0000_0100);
        pre(16'h0001, 1'b0, 32'h0000_0100);
        $display("test preload done");
    endtask

    initial begin
        {sys_rst_n, rst_req, cmd_req, enh_vld, pre_wr} = '0;
        {cmd_idx, cmd_arg, enh_size, pre_bytes} = '0;
        fn_en = 1'b1;
        repeat (8) @(posedge clk);
        sys_rst_n <= 1'b1;
        @(negedge clk);
        t_power();
        t_reset();
        t_cmds();
        t_pre();
        conclude();
    end

    initial begin
        #(25 * 5000);
        n_mismatch++;
        $display("FAIL %0t watchdog expired", $time);
        conclude();
    end
endmodule
